/* File: rtl/sfr_array.sv */
// Purpose: byte array behind the read engine
// Assumes: one write port, two asynchronous read ports
// Notes: no reset; contents are loaded over the register bus
`timescale 1ns/1ns
module sfr_array #(
  parameter int AW = 21
) (
  // clock
  input  wire logic          clock,
  // write port
  input  wire logic          wrEn,
  input  wire logic [AW-1:0] wrAddr,
  input  wire logic [7:0]    wrData,
  // read ports
  input  wire logic [AW-1:0] rdAddrA,
  output logic      [7:0]    rdDataA,
  input  wire logic [AW-1:0] rdAddrB,
  output logic      [7:0]    rdDataB
);

  logic [7:0] mem [2**AW];

  // byte store
  always_ff @(posedge clock)
  begin
    if (wrEn)
      mem[wrAddr] <= wrData;
  end

  // combinational reads keep the serial launch free of latency
  assign rdDataA = mem[rdAddrA];
  assign rdDataB = mem[rdAddrB];

endmodule

/* File: rtl/sfr_read_engine.sv */
// Purpose: serial flash read path with APB control and array load
// Assumes: sck far slower than clock; pins sampled by two flops
// Notes: io1 is the single-line output, io0 the single-line input
`timescale 1ns/1ns
`include "sfr_map.svh"
module sfr_read_engine #(
  parameter int ARRAY_AW = `SFR_ARRAY_AW
) (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        resetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // flash pins
  input  wire logic        csN,
  input  wire logic        sck,
  input  wire logic        holdN,
  input  wire logic [3:0]  ioIn,
  output logic      [3:0]  ioOut,
  output logic      [3:0]  ioOeN
);

  sfr_pkg::sfr_pins_t  pinsRaw;
  sfr_pkg::sfr_pins_t  pinsS;
  sfr_pkg::sfr_ctrl_t  ctrl_r;
  sfr_pkg::sfr_dummy_t dummy_r;
  sfr_pkg::sfr_state_t st_r;
  sfr_pkg::sfr_state_t stEff;
  sfr_pkg::sfr_state_t decSt;
  sfr_pkg::sfr_kind_t  kind_r;
  sfr_pkg::sfr_kind_t  kindEff;
  sfr_pkg::sfr_kind_t  decKind;
  logic                sckPrev_r;
  logic                sckRise;
  logic                sckFall;
  logic                holdAct_r;
  logic                holdEn;
  logic                step;
  logic [3:0]          perCnt_r;
  logic                tooFast_r;
  logic                curFast;
  logic                contMode_r;
  logic [4:0]          cnt_r;
  logic [7:0]          op_r;
  logic [23:0]         addrSh_r;
  logic [7:0]          modeSh_r;
  logic [3:0]          dummyLen_r;
  logic [ARRAY_AW-1:0] addr_r;
  logic [2:0]          lanesCmd;
  logic [2:0]          lanesEff;
  logic [4:0]          opClks;
  logic [4:0]          addrClks;
  logic [23:0]         opWide;
  logic [23:0]         addrNxt;
  logic [23:0]         modeWide;
  logic                riseOk;
  logic                addrDone;
  logic                modeDone;
  logic                dataFall;
  logic [2:0]          bytePos_r;
  logic [7:0]          outSh_r;
  logic [7:0]          curByte;
  logic [7:0]          memRd;
  logic                driving_r;
  logic [ARRAY_AW-1:0] memAddr_r;
  logic [7:0]          memApb;
  logic                apbSetup;
  logic                apbWrite;

  // lane gather: new bits enter at the lsb end, msb on highest line
  function automatic logic [23:0] shiftIn(input logic [23:0] sh,
                                          input logic [3:0]  io,
                                          input logic [2:0]  lanes);
    case (lanes)
      3'h4:    shiftIn = {sh[19:0], io};
      3'h2:    shiftIn = {sh[21:0], io[1:0]};
      default: shiftIn = {sh[22:0], io[0]};
    endcase
  endfunction

  // clocks needed to move a field over the given lane count
  function automatic logic [4:0] clocksFor(input logic [4:0] bits,
                                           input logic [2:0] lanes);
    case (lanes)
      3'h4:    clocksFor = bits >> 2;
      3'h2:    clocksFor = bits >> 1;
      default: clocksFor = bits;
    endcase
  endfunction

  // lanes used for address and data of a read kind
  function automatic logic [2:0] laneOf(input sfr_pkg::sfr_kind_t k);
    case (k)
      sfr_pkg::RD_DUAL: laneOf = 3'h2;
      sfr_pkg::RD_QUAD: laneOf = 3'h4;
      default:          laneOf = 3'h1;
    endcase
  endfunction

  // top bits of a byte onto the pins; single line goes out on io1
  function automatic logic [3:0] drive(input logic [7:0] b,
                                       input logic [2:0] lanes);
    case (lanes)
      3'h4:    drive = b[7:4];
      3'h2:    drive = {2'h0, b[7:6]};
      default: drive = {2'h0, b[7], 1'h0};
    endcase
  endfunction

  // lines driven for a lane count
  function automatic logic [3:0] laneMask(input logic [2:0] lanes);
    case (lanes)
      3'h4:    laneMask = 4'hf;
      3'h2:    laneMask = 4'h3;
      default: laneMask = 4'h2;
    endcase
  endfunction

  // pin synchroniser
  assign pinsRaw = '{io: ioIn, holdN: holdN, sck: sck, csN: csN};

  sfr_sync #(
    .WIDTH ($bits(sfr_pkg::sfr_pins_t))
  ) uSync (
    .clock  (clock),
    .resetn (resetn),
    .din    (pinsRaw),
    .dout   (pinsS)
  );

  // byte array, port a for the serial side, port b for apb
  sfr_array #(
    .AW (ARRAY_AW)
  ) uArray (
    .clock   (clock),
    .wrEn    (apbWrite && (paddr == `SFR_MDATA_OFS)),
    .wrAddr  (memAddr_r),
    .wrData  (pwdata[7:0]),
    .rdAddrA (addr_r),
    .rdDataA (memRd),
    .rdAddrB (memAddr_r),
    .rdDataB (memApb)
  );

  // sck edge finder on the synchronised level
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      sckPrev_r <= 1'h1;
    else
      sckPrev_r <= pinsS.sck;
  end

  assign sckRise = pinsS.sck & ~sckPrev_r;
  assign sckFall = ~pinsS.sck & sckPrev_r;

  // sck period meter; saturates so the first edge never looks fast
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      perCnt_r <= 4'hf;
    else if (pinsS.csN)
      perCnt_r <= 4'hf;
    else if (sckRise)
      perCnt_r <= 4'h0;
    else if (perCnt_r != 4'hf)
      perCnt_r <= perCnt_r + 4'h1;
  end

  assign curFast = sckRise &&
    (({1'h0, perCnt_r} + 5'h01) < 5'(`SFR_NORMAL_MIN_CYC));

  // any fast edge in this selection up to the last opcode clock disqualifies a normal read
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      tooFast_r <= 1'h0;
    else if (pinsS.csN)
      tooFast_r <= 1'h0;
    else if (curFast)
      tooFast_r <= 1'h1;
  end

  // hold: follows holdN only while sck is low; deselect or a hold-disabling ctrl bit clears it at once
  assign holdEn = ~(ctrl_r.dtr | ctrl_r.quadEnable | ctrl_r.holdAsReset |
                    ctrl_r.fourLine);

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      holdAct_r <= 1'h0;
    else if (pinsS.csN || !holdEn)
      holdAct_r <= 1'h0;
    else if (!pinsS.sck)
      holdAct_r <= ~pinsS.holdN;
  end

  // no progress while held, so the sequence resumes where it paused
  assign step = ~holdAct_r & ~pinsS.csN;

  // a fresh selection starts at the opcode, or at the address in
  // continuous mode; busy discards the opcode-less read too
  always_comb
  begin
    stEff   = st_r;
    kindEff = kind_r;
    if (st_r == sfr_pkg::ST_IDLE)
    begin
      if (contMode_r)
      begin
        stEff   = ctrl_r.busy ? sfr_pkg::ST_IGNORE
                              : sfr_pkg::ST_ADDR;
        kindEff = sfr_pkg::RD_DUAL;
      end
      else
        stEff = sfr_pkg::ST_OPCODE;
    end
  end

  assign lanesCmd = ctrl_r.fourLine ? 3'h4 : 3'h1;
  assign lanesEff = laneOf(kindEff);
  assign opClks   = clocksFor(`SFR_OP_BITS, lanesCmd);
  assign addrClks = clocksFor(`SFR_ADDR_BITS, lanesEff);
  assign opWide   = shiftIn({16'h0000, op_r}, pinsS.io, lanesCmd);
  assign addrNxt  = shiftIn(addrSh_r, pinsS.io, lanesEff);
  assign modeWide = shiftIn({16'h0000, modeSh_r}, pinsS.io, 3'h2);

  assign riseOk   = step & sckRise;
  assign addrDone = riseOk && (stEff == sfr_pkg::ST_ADDR) &&
                    (cnt_r == addrClks - 5'h01);
  assign modeDone = riseOk && (stEff == sfr_pkg::ST_MODE) &&
                    (cnt_r == `SFR_MODE_CLKS - 5'h01);
  assign dataFall = step & sckFall & (st_r == sfr_pkg::ST_DATA);

  // opcode decode
  always_comb
  begin
    decSt   = sfr_pkg::ST_IGNORE;
    decKind = sfr_pkg::RD_NORMAL;
    if (ctrl_r.busy)
      decSt = sfr_pkg::ST_IGNORE;
    else if (ctrl_r.fourLine)
    begin
      case (opWide[7:0])
        `SFR_OP_FAST, `SFR_OP_QUAD, `SFR_OP_UID, `SFR_OP_INFO:
        begin
          decSt   = sfr_pkg::ST_ADDR;
          decKind = sfr_pkg::RD_QUAD;
        end
        default: decSt = sfr_pkg::ST_IGNORE;
      endcase
    end
    else
    begin
      case (opWide[7:0])
        `SFR_OP_NORMAL:
        begin
          decSt = (tooFast_r | curFast) ? sfr_pkg::ST_IGNORE
                                        : sfr_pkg::ST_ADDR;
          decKind = sfr_pkg::RD_NORMAL;
        end
        `SFR_OP_FAST:
        begin
          decSt   = sfr_pkg::ST_ADDR;
          decKind = sfr_pkg::RD_FAST;
        end
        `SFR_OP_DUAL:
        begin
          decSt   = sfr_pkg::ST_ADDR;
          decKind = sfr_pkg::RD_DUAL;
        end
        default: decSt = sfr_pkg::ST_IGNORE;
      endcase
    end
  end

  // command sequencer, advanced on rising sck only
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      st_r       <= sfr_pkg::ST_IDLE;
      kind_r     <= sfr_pkg::RD_NORMAL;
      cnt_r      <= 5'h00;
      op_r       <= 8'h00;
      addrSh_r   <= 24'h000000;
      modeSh_r   <= 8'h00;
      dummyLen_r <= 4'h0;
    end
    else if (pinsS.csN)
    begin
      st_r     <= sfr_pkg::ST_IDLE;
      cnt_r    <= 5'h00;
      op_r     <= 8'h00;
      addrSh_r <= 24'h000000;
    end
    else if (riseOk)
    begin
      case (stEff)
        sfr_pkg::ST_OPCODE:
        begin
          op_r <= opWide[7:0];
          if (cnt_r == opClks - 5'h01)
          begin
            cnt_r  <= 5'h00;
            st_r   <= decSt;
            kind_r <= decKind;
          end
          else
          begin
            cnt_r <= cnt_r + 5'h01;
            st_r  <= sfr_pkg::ST_OPCODE;
          end
        end
        sfr_pkg::ST_ADDR:
        begin
          addrSh_r <= addrNxt;
          kind_r   <= kindEff;
          cnt_r    <= addrDone ? 5'h00 : cnt_r + 5'h01;
          st_r     <= sfr_pkg::ST_ADDR;
          if (addrDone)
          begin
            case (kindEff)
              sfr_pkg::RD_NORMAL: st_r <= sfr_pkg::ST_DATA;
              sfr_pkg::RD_DUAL:   st_r <= sfr_pkg::ST_MODE;
              sfr_pkg::RD_FAST:
              begin
                dummyLen_r <= dummy_r.fast;
                st_r <= (dummy_r.fast == 4'h0) ? sfr_pkg::ST_DATA
                                               : sfr_pkg::ST_DUMMY;
              end
              default:
              begin
                dummyLen_r <= dummy_r.quad;
                st_r <= (dummy_r.quad == 4'h0) ? sfr_pkg::ST_DATA
                                               : sfr_pkg::ST_DUMMY;
              end
            endcase
          end
        end
        sfr_pkg::ST_MODE:
        begin
          modeSh_r <= modeWide[7:0];
          cnt_r    <= modeDone ? 5'h00 : cnt_r + 5'h01;
          if (modeDone)
          begin
            // mode clocks count as dummies; data follows when used up
            dummyLen_r <= dummy_r.dual - 4'(`SFR_MODE_CLKS);
            st_r <= (dummy_r.dual <= 4'(`SFR_MODE_CLKS))
                    ? sfr_pkg::ST_DATA : sfr_pkg::ST_DUMMY;
          end
        end
        sfr_pkg::ST_DUMMY:
        begin
          if (cnt_r == {1'h0, dummyLen_r} - 5'h01)
          begin
            cnt_r <= 5'h00;
            st_r  <= sfr_pkg::ST_DATA;
          end
          else
            cnt_r <= cnt_r + 5'h01;
        end
        // input no longer sampled once data flows
        sfr_pkg::ST_DATA:   st_r <= sfr_pkg::ST_DATA;
        sfr_pkg::ST_IGNORE: st_r <= sfr_pkg::ST_IGNORE;
        default:            st_r <= sfr_pkg::ST_IDLE;
      endcase
    end
  end

  // continuous mode survives deselect; only the mode nibble moves it
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      contMode_r <= 1'h0;
    else if (modeDone)
      contMode_r <= (modeWide[7:4] == `SFR_MODE_CONT);
  end

  // read address: low bits taken, then stepped after each byte
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      addr_r <= '0;
    else if (addrDone)
      addr_r <= addrNxt[ARRAY_AW-1:0];
    else if (dataFall && (bytePos_r == 3'(clocksFor(5'h08, lanesEff)
                                       - 5'h01)))
      addr_r <= addr_r + 1'b1;
  end

  assign curByte = (bytePos_r == 3'h0) ? memRd : outSh_r;

  // data launch on falling sck, msb first
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      ioOut     <= 4'h0;
      outSh_r   <= 8'h00;
      bytePos_r <= 3'h0;
    end
    else if (st_r != sfr_pkg::ST_DATA)
      bytePos_r <= 3'h0;
    else if (dataFall)
    begin
      ioOut   <= drive(curByte, lanesEff);
      outSh_r <= curByte << lanesEff;
      if (bytePos_r == 3'(clocksFor(5'h08, lanesEff) - 5'h01))
        bytePos_r <= 3'h0;
      else
        bytePos_r <= bytePos_r + 3'h1;
    end
  end

  // output enable follows the first launch; lags data by one clock
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      driving_r <= 1'h0;
    else if (st_r != sfr_pkg::ST_DATA)
      driving_r <= 1'h0;
    else if (dataFall)
      driving_r <= 1'h1;
  end

  // float on deselect or hold straight away
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      ioOeN <= 4'hf;
    else if (pinsS.csN || holdAct_r || !driving_r)
      ioOeN <= 4'hf;
    else
      ioOeN <= ~laneMask(lanesEff);
  end

  // apb: zero wait, read data captured in the setup cycle
  assign pready   = 1'h1;
  assign apbSetup = psel & ~penable;
  assign apbWrite = psel & penable & pwrite;

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      prdata  <= 32'h00000000;
      pslverr <= 1'h0;
    end
    else if (apbSetup)
    begin
      prdata  <= 32'h00000000;
      pslverr <= 1'h0;
      case (paddr)
        `SFR_CTRL_OFS:   prdata <= {27'h0000000, ctrl_r};
        `SFR_DUMMY_OFS:  prdata <= {20'h00000, dummy_r};
        `SFR_STATUS_OFS:
        begin
          prdata[`SFR_ST_SEL_BIT]  <= ~pinsS.csN;
          prdata[`SFR_ST_CONT_BIT] <= contMode_r;
          prdata[`SFR_ST_HOLD_BIT] <= holdAct_r;
          prdata[`SFR_ST_STATE_LSB +: 3] <= st_r;
          prdata[`SFR_ST_KIND_LSB +: 2]  <= kind_r;
        end
        `SFR_MADDR_OFS:  prdata <= 32'(memAddr_r);
        `SFR_MDATA_OFS:  prdata <= {24'h000000, memApb};
        default:         pslverr <= 1'h1;
      endcase
    end
  end

  // writable registers
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      ctrl_r  <= sfr_pkg::sfr_ctrl_t'(`SFR_CTRL_RST);
      dummy_r <= sfr_pkg::sfr_dummy_t'(`SFR_DUMMY_RST);
    end
    else if (apbWrite && (paddr == `SFR_CTRL_OFS))
      ctrl_r <= sfr_pkg::sfr_ctrl_t'(pwdata[4:0]);
    else if (apbWrite && (paddr == `SFR_DUMMY_OFS))
      dummy_r <= sfr_pkg::sfr_dummy_t'(pwdata[11:0]);
  end

  // array load pointer, stepping after each data write
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      memAddr_r <= '0;
    else if (apbWrite && (paddr == `SFR_MADDR_OFS))
      memAddr_r <= pwdata[ARRAY_AW-1:0];
    else if (apbWrite && (paddr == `SFR_MDATA_OFS))
      memAddr_r <= memAddr_r + 1'b1;
  end

endmodule

/* File: rtl/sfr_sync.sv */
// Purpose: two-flop synchroniser for the flash pins
// Assumes: each bit is an independent level
// Notes: first stage feeds only the second stage
`timescale 1ns/1ns
module sfr_sync #(
  parameter int WIDTH = 7
) (
  // clock and reset
  input  wire logic             clock,
  input  wire logic             resetn,
  // pins in, synchronised out
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] meta_r;

  // resets high so a deselected idle bus is seen
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      meta_r <= '1;
      dout   <= '1;
    end
    else
    begin
      meta_r <= din;
      dout   <= meta_r;
    end
  end

endmodule

/* File: shared/sfr_map.svh */
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: 32-bit APB, one aligned word per register
// Notes: included by bare name, guarded against double inclusion
`ifndef SFR_MAP_SVH
`define SFR_MAP_SVH

// read opcodes
`define SFR_OP_NORMAL      8'h03
`define SFR_OP_FAST        8'h0b
`define SFR_OP_DUAL        8'hbb
`define SFR_OP_QUAD        8'heb
`define SFR_OP_UID         8'h4b
`define SFR_OP_INFO        8'h68

// framing
`define SFR_OP_BITS        5'h08
`define SFR_ADDR_BITS      5'h18
`define SFR_ARRAY_AW       21
`define SFR_MODE_CLKS      5'h04
`define SFR_MODE_CONT      4'ha

// timing: normal read ceiling and its least sck period in clocks
`define SFR_CLK_MHZ        100
`define SFR_NORMAL_MAX_MHZ 50
`define SFR_NORMAL_MIN_NS  (1000 / `SFR_NORMAL_MAX_MHZ)
`define SFR_NORMAL_MIN_CYC ((`SFR_NORMAL_MIN_NS * `SFR_CLK_MHZ + 999) / 1000)

// register byte offsets
`define SFR_CTRL_OFS       8'h00
`define SFR_DUMMY_OFS      8'h04
`define SFR_STATUS_OFS     8'h08
`define SFR_MADDR_OFS      8'h0c
`define SFR_MDATA_OFS      8'h10

// reset values
`define SFR_CTRL_RST       5'h00
`define SFR_DUMMY_RST      12'h468

// status field positions
`define SFR_ST_SEL_BIT     0
`define SFR_ST_CONT_BIT    1
`define SFR_ST_HOLD_BIT    2
`define SFR_ST_STATE_LSB   4
`define SFR_ST_KIND_LSB    8

`endif

/* File: shared/sfr_pkg.sv */
// Purpose: types shared by the read engine files
// Assumes: constants live in sfr_map.svh
// Notes: packed struct fields listed msb first
package sfr_pkg;

  typedef enum logic [2:0] {
    ST_IDLE, ST_OPCODE, ST_ADDR, ST_MODE, ST_DUMMY, ST_DATA, ST_IGNORE
  } sfr_state_t;

  typedef enum logic [1:0] {
    RD_NORMAL, RD_FAST, RD_DUAL, RD_QUAD
  } sfr_kind_t;

  typedef struct packed {
    logic busy;
    logic holdAsReset;
    logic dtr;
    logic quadEnable;
    logic fourLine;
  } sfr_ctrl_t;

  typedef struct packed {
    logic [3:0] dual;
    logic [3:0] quad;
    logic [3:0] fast;
  } sfr_dummy_t;

  typedef struct packed {
    logic [3:0] io;
    logic       holdN;
    logic       sck;
    logic       csN;
  } sfr_pins_t;

endpackage

/* File: verification/sfr_read_engine_bench.sv */
// Purpose: self-checking bench for the read engine
// Assumes: array width cut to 10 bits so the wrap is reachable
// Notes: array contents loaded over apb before any frame
`timescale 1ns/1ns
module sfr_read_engine_bench;
  logic        clock;
  logic        resetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        csN;
  logic        sck;
  logic        holdN;
  logic [3:0]  ioIn;
  logic [3:0]  ioOut;
  logic [3:0]  ioOeN;
  logic [31:0] rdVal;
  logic [31:0] e;
  logic        errVal;
  logic [9:0]  a;
  logic [7:0]  ops [4];
  int          miscompares;
  int          compares;
  int          cycles;

  sfr_read_engine #(.ARRAY_AW(10)) dut_u (
    .clock, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .csN, .sck, .holdN, .ioIn, .ioOut, .ioOeN
  );
  sfr_spi_host host_u (.clock, .csN, .sck, .holdN, .ioIn, .ioOut, .ioOeN);

  // 100 MHz clock
  initial
  begin
    clock = 1'b0;
    cycles = 0;
  end
  always #5 clock = ~clock;
  // hang guard, far above the expected run
  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (cycles == 30000)
    begin
      miscompares++;
      complete_run();
    end
  end

  function automatic logic [7:0] dat(input logic [9:0] x);
    return x[7:0] ^ {6'h29, x[9:8]};
  endfunction
  function automatic logic [31:0] ex(input logic [9:0] s);
    ex = 32'h0;
    for (int i = 0; i < 4; i++)
      ex = {ex[23:0], dat(s + 10'(i))};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // apb transfer, held until pready is seen at an edge
  task automatic bus(input logic w, input logic [7:0] ad,
                     input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rdVal = prdata;
    errVal = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // one read frame; hp data clocks in, a hold pause is inserted
  // so the float during hold is seen while the device drives
  task automatic frame(input logic dual, input int hp, input logic [31:0] v,
                       input int n, input int w, input int dum, input int dc);
    host_u.start();
    if (dual)
      host_u.shift({8'hbb, 24'h0}, 8, 1, 1'b1);
    host_u.shift(v, n, w, 1'b1);
    host_u.shift(32'h0, dum, w, 1'b0);
    if (hp > 0)
    begin
      host_u.shift(32'h0, hp, w, 1'b0);
      host_u.pause();
    end
    host_u.shift(32'h0, dc - hp, w, 1'b0);
    host_u.stop();
  endtask
  task automatic complete_run();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // main sequence
  initial
  begin
    resetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    miscompares = 0;
    compares = 0;
    ops = '{8'h0b, 8'heb, 8'h4b, 8'h68};
    repeat (20) @(posedge clock);
    resetn <= 1'b1;
    bus(1'b0, 8'h04, 32'h0);
    chk(rdVal, 32'h468);
    bus(1'b0, 8'h20, 32'h0);
    chk({31'h0, errVal}, 32'h1);
    for (int k = 0; k < 8; k++)
    begin
      a = 10'h3fc + 10'(k);
      if (k % 4 == 0)
        bus(1'b1, 8'h0c, {22'h0, a});
      bus(1'b1, 8'h10, {24'h0, dat(a)});
    end
    bus(1'b1, 8'h0c, 32'h3fd);
    bus(1'b0, 8'h10, 32'h0);
    chk(rdVal, {24'h0, dat(10'h3fd)});
    $display("registers done");
    frame(1'b0, 0, {8'h03, 24'he003fe}, 32, 1, 0, 32);
    chk(host_u.rx, ex(10'h3fe));
    frame(1'b0, 4, {8'h0b, 24'h0003fc}, 32, 1, 8, 16);
    e = ex(10'h3fc);
    chk({16'h0, host_u.rx[15:0]}, {16'h0, e[31:16]});
    $display("single line reads done");
    bus(1'b1, 8'h00, 32'h10);
    frame(1'b0, 0, {8'h03, 24'h0}, 32, 1, 0, 8);
    chk({31'h0, host_u.drove}, 32'h0);
    bus(1'b1, 8'h00, 32'h1);
    for (int i = 0; i < 4; i++)
    begin
      frame(1'b0, 0, {ops[i], 24'h0003fe}, 8, 4, 6, 8);
      chk(host_u.rx, ex(10'h3fe));
    end
    bus(1'b1, 8'h00, 32'h0);
    $display("busy and four-line done");
    frame(1'b1, 0, {24'h0003fd, 8'ha0}, 14, 2, 2, 16);
    chk(host_u.rx, ex(10'h3fd));
    frame(1'b0, 0, {24'h0, 8'h50}, 14, 2, 2, 16);
    chk(host_u.rx, ex(10'h000));
    frame(1'b0, 0, {8'h03, 24'h0003fc}, 32, 1, 0, 32);
    chk(host_u.rx, ex(10'h3fc));
    $display("dual reads done");
    complete_run();
  end
endmodule

/* File: verification/sfr_read_engine_properties.sv */
// Purpose: port checks on the read engine
// Assumes: sck half period of 8 clocks, pins pass a 2-flop sync
// Notes: pin windows allow 5 clocks of sync and register delay
`timescale 1ns/1ns
module sfr_read_engine_properties (
  // clock and reset
  input logic        clock,
  input logic        resetn,
  // apb
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [7:0]  paddr,
  input logic [31:0] pwdata,
  input logic [31:0] prdata,
  input logic        pready,
  input logic        pslverr,
  // flash pins
  input logic        csN,
  input logic        sck,
  input logic        holdN,
  input logic [3:0]  ioIn,
  input logic [3:0]  ioOut,
  input logic [3:0]  ioOeN
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (!resetn);
  // setup cycles split by mapped offset
  sequence s_bad_setup;
    psel && !penable && paddr > 8'h10;
  endsequence
  sequence s_good_setup;
    psel && !penable && paddr <= 8'h10 && paddr[1:0] == 2'h0;
  endsequence
  a_bad_offset: assert property (s_bad_setup ##1 penable |-> pslverr)
    else $error("unmapped offset without error");
  a_good_offset: assert property (s_good_setup ##1 penable |-> !pslverr)
    else $error("mapped offset flagged as error");
  a_pready_one: assert property (pready)
    else $error("wait state inserted");
  a_deselect_float: assert property (csN [*6] |-> ioOeN == 4'hf)
    else $error("line driven while deselected");
  a_hold_float: assert property (
    (!csN && !holdN && !sck) [*6] |-> ioOeN == 4'hf)
    else $error("line driven during hold");
  a_lane_codes: assert property (ioOeN inside {4'hf, 4'hd, 4'hc, 4'h0})
    else $error("illegal lane enable pattern");
  a_out_on_fall: assert property (
    !csN && !ioOeN[1] && $changed(ioOut) |-> !sck)
    else $error("data launched outside sck low");
  a_drive_steady: assert property (
    !csN && holdN && ioOeN != 4'hf |=> ioOeN == $past(ioOeN))
    else $error("lane enable changed mid frame");
endmodule

bind sfr_read_engine sfr_read_engine_properties chk_u (
  .clock, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
  .pready, .pslverr, .csN, .sck, .holdN, .ioIn, .ioOut, .ioOeN
);

/* File: verification/sfr_spi_host.sv */
// Purpose: spi host model driving the flash pins
// Assumes: sck half period of 8 clocks, 80 ns
// Notes: released lines toggle each clock so stale data never matches
`timescale 1ns/1ns
module sfr_spi_host (
  // clock
  input  logic       clock,
  // flash pins
  output logic       csN,
  output logic       sck,
  output logic       holdN,
  output logic [3:0] ioIn,
  input  logic [3:0] ioOut,
  input  logic [3:0] ioOeN
);
  logic [3:0]  hostOut;
  logic [3:0]  hostOe;
  logic        flip;
  logic        drove;
  logic [31:0] rx;
  // wire level: device wins, then host, else a toggling float
  assign ioIn = (~ioOeN & ioOut) | (ioOeN & hostOe & hostOut)
              | (ioOeN & ~hostOe & {4{flip}});
  // idle pins at time zero
  initial
  begin
    csN = 1'b1;
    sck = 1'b0;
    holdN = 1'b1;
    hostOe = 4'h0;
    hostOut = 4'h0;
    flip = 1'b0;
  end
  // float pattern and record of any device drive
  always @(posedge clock)
  begin
    flip <= ~flip;
    if (ioOeN != 4'hf)
      drove <= 1'b1;
  end
  // one sck period per step, msb first on the top lane
  task automatic shift(input logic [31:0] v, input int n, input int w,
                       input logic drv);
    for (int i = 0; i < n; i++)
    begin
      sck <= 1'b0;
      hostOut <= v[31:28] >> (4 - w);
      hostOe <= drv ? 4'hf >> (4 - w) : 4'h0;
      v = v << w;
      repeat (7) @(posedge clock);
      rx = w == 1 ? {rx[30:0], ioIn[1]} : w == 2 ? {rx[29:0], ioIn[1:0]}
         : {rx[27:0], ioIn};
      @(posedge clock);
      sck <= 1'b1;
      repeat (8) @(posedge clock);
    end
  endtask
  task automatic start();
    drove = 1'b0;
    @(posedge clock);
    csN <= 1'b0;
    sck <= 1'b0;
    repeat (8) @(posedge clock);
  endtask
  // deselect only after whole bytes
  task automatic stop();
    sck <= 1'b0;
    repeat (8) @(posedge clock);
    csN <= 1'b1;
    hostOe <= 4'h0;
    repeat (16) @(posedge clock);
  endtask
  // hold with sck low, sck and data keep toggling meanwhile
  task automatic pause();
    sck <= 1'b0;
    repeat (8) @(posedge clock);
    holdN <= 1'b0;
    repeat (4)
    begin
      repeat (8) @(posedge clock);
      sck <= ~sck;
      hostOut <= ~hostOut;
    end
    repeat (8) @(posedge clock);
    holdN <= 1'b1;
    repeat (8) @(posedge clock);
  endtask
endmodule
